// ### inc/wdt_pkg.sv
package wdt_pkg;

    // ----------------------------------------
    // Bus and register map
    // ----------------------------------------
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam logic [7:0] OFF_MODE      = 8'h00;
    localparam logic [7:0] OFF_CLEAR     = 8'h04;
    localparam logic [7:0] OFF_CLEAR_BIT = 8'h08;
    localparam logic [7:0] OFF_MODE_BIT  = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_MASK      = 8'h14;
    localparam logic [7:0] OFF_STATE     = 8'h18;

    // ----------------------------------------
    // Mode register fields and codes
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET    = 8'h67;
    localparam logic [2:0] MODE_FIXED    = 3'h3;
    localparam int         MODE_FIX_HI   = 7;
    localparam int         MODE_FIX_LO   = 5;
    localparam int         MODE_STOP_BIT = 4;
    localparam int         MODE_SRC_BIT  = 3;
    localparam int         MODE_SEL_HI   = 2;
    localparam logic [7:0] CLEAR_CODE    = 8'hac;
    localparam logic [7:0] CLEAR_READ    = 8'h9a;

    // ----------------------------------------
    // Event status bits
    // ----------------------------------------
    localparam int         ST_W          = 4;
    localparam int         ST_MODE       = 0;
    localparam int         ST_VIOL       = 1;
    localparam int         ST_OVF        = 2;
    localparam int         ST_RST        = 3;
    localparam logic [3:0] ST_RESET      = 4'h0;

    // ----------------------------------------
    // Counter and timing
    // ----------------------------------------
    localparam int         CNT_W         = 18;
    localparam int         CNT_MIN_BIT   = 10;
    localparam int         STATE_FLAG_LO = 28;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_MODE, SEL_CLEAR, SEL_CLEAR_BIT,
        SEL_MODE_BIT, SEL_STATUS, SEL_MASK, SEL_STATE
    } sel_e;

    // Address decode shared by bus logic and checks
    function automatic sel_e decode(input logic [ADDR_W-1:0] a);
        sel_e s;
        s = SEL_NONE;
        case (a)
            OFF_MODE:      s = SEL_MODE;
            OFF_CLEAR:     s = SEL_CLEAR;
            OFF_CLEAR_BIT: s = SEL_CLEAR_BIT;
            OFF_MODE_BIT:  s = SEL_MODE_BIT;
            OFF_STATUS:    s = SEL_STATUS;
            OFF_MASK:      s = SEL_MASK;
            OFF_STATE:     s = SEL_STATE;
            default:       s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

endpackage : wdt_pkg

// ### hdl/wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
    parameter int CNT_W = wdt_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Control
    input  wire logic             tick,
    input  wire logic             clear,
    input  wire logic [2:0]       sel,
    // Status
    output logic      [CNT_W-1:0] count,
    output logic                  overflow
);
    import wdt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             ovf;
    } cnt_s;

    cnt_s st;
    cnt_s next_st;
    logic hit;

    // Overflow when the selected bit is reached
    assign hit = st.count[CNT_MIN_BIT + int'(sel)];

    // Clear beats a tick so a clear never loses to a wrap
    always_comb begin
        next_st = st;
        next_st.ovf = 1'b0;
        if (clear) begin
            next_st.count = '0;
        end else if (tick && hit) begin
            next_st.count = '0;
            next_st.ovf = 1'b1;
        end else if (tick) begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign overflow = st.ovf;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    AST_CLEAR_ZERO: assert property (clear |=> count == '0 && !overflow)
        else $error("counter not zero after clear");
endmodule : wdt_counter
`default_nettype wire

// ### hdl/wdt_rst_defer.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_rst_defer (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Cause and source state
    input  wire logic cause,
    input  wire logic src_run,
    // Result
    output logic      pending,
    output logic      fire
);
    typedef struct packed {
        logic pend;
        logic fire;
    } defer_s;

    defer_s st;
    defer_s next_st;

    // Hold the cause while the source clock stands still
    always_comb begin
        next_st = st;
        next_st.fire = 1'b0;
        if ((st.pend || cause) && src_run) begin
            next_st.fire = 1'b1;
            next_st.pend = 1'b0;
        end else if (cause) begin
            next_st.pend = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pending = st.pend;
    assign fire = st.fire;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence held_cause;
        pending && !src_run;
    endsequence

    AST_DEFER_RST: assert property (held_cause |=> !fire && pending)
        else $error("reset fired while source clock stopped");
endmodule : wdt_rst_defer
`default_nettype wire

// ### hdl/wdt_guard.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wdt_guard (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [wdt_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [wdt_pkg::DATA_W-1:0]    pwdata,
    output logic      [wdt_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Count sources and power state
    input  wire logic                          tick_osc,
    input  wire logic                          tick_sys,
    input  wire logic                          osc_stoppable,
    input  wire logic                          halt_stop,
    // Results
    output logic                               wdt_rst,
    output logic                               irq
);
    import wdt_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_DONE
    } bus_e;

    typedef struct packed {
        bus_e              bus;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        logic [7:0]        mode;
        logic              mode_written;
        logic              opt_stoppable;
        logic              opt_taken;
        logic              stopped;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic              irq;
        logic              clear_req;
        logic              viol;
    } guard_s;

    guard_s st;
    guard_s next_st;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    sel_e             sel;
    logic             setup;
    logic             fire;
    logic             wr_fire;
    logic             src_run;
    logic             tick;
    logic [CNT_W-1:0] count;
    logic             overflow;
    logic             pending;
    logic             rst_fire;
    logic [ST_W-1:0]  set_bits;
    logic [DATA_W-1:0] rd_word;

    assign sel = decode(paddr);
    assign setup = psel && !penable;
    assign fire = psel && penable && st.pready;
    assign wr_fire = fire && pwrite;

    // Source stands still only when the oscillator may be stopped
    assign src_run = !(st.opt_stoppable && (st.stopped || halt_stop));

    // Selected source, gated by the run condition
    assign tick = src_run && (st.mode[MODE_SRC_BIT] ? tick_sys : tick_osc);

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    // Registered into prdata at the setup edge, with pready except for mode writes
    always_comb begin
        rd_word = '0;
        case (sel)
            SEL_MODE:      rd_word[7:0] = st.mode;
            SEL_CLEAR:     rd_word[7:0] = CLEAR_READ;
            SEL_CLEAR_BIT: rd_word[7:0] = CLEAR_READ;
            SEL_MODE_BIT:  rd_word[7:0] = st.mode;
            SEL_STATUS:    rd_word[ST_W-1:0] = st.status;
            SEL_MASK:      rd_word[ST_W-1:0] = st.mask;
            SEL_STATE: begin
                rd_word[CNT_W-1:0] = count;
                rd_word[STATE_FLAG_LO+3] = st.mode_written;
                rd_word[STATE_FLAG_LO+2] = st.stopped;
                rd_word[STATE_FLAG_LO+1] = pending;
                rd_word[STATE_FLAG_LO]   = st.opt_stoppable;
            end
            default:       rd_word = '0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.clear_req = 1'b0;
        next_st.viol = 1'b0;
        set_bits = '0;

        // Option strap caught once, one cycle after reset release
        if (!st.opt_taken) begin
            next_st.opt_stoppable = osc_stoppable;
            next_st.opt_taken = 1'b1;
        end

        // Bus phases: answer is registered, mode writes get one wait
        case (st.bus)
            BUS_IDLE: begin
                if (setup) begin
                    next_st.prdata = rd_word;
                    next_st.pslverr = (sel == SEL_NONE);
                    if (pwrite && sel == SEL_MODE) begin
                        next_st.bus = BUS_WAIT;
                    end else begin
                        next_st.bus = BUS_DONE;
                        next_st.pready = 1'b1;
                    end
                end
            end
            BUS_WAIT: begin
                next_st.bus = BUS_DONE;
                next_st.pready = 1'b1;
            end
            BUS_DONE: begin
                if (fire) begin
                    next_st.bus = BUS_IDLE;
                    next_st.pready = 1'b0;
                    next_st.pslverr = 1'b0;
                    next_st.prdata = '0;
                end
            end
            default: begin
                next_st.bus = BUS_IDLE;
                next_st.pready = 1'b0;
            end
        endcase

        // Register writes take effect at the completing edge
        if (wr_fire) begin
            case (sel)
                SEL_MODE: begin
                    if (st.mode_written) begin
                        next_st.viol = 1'b1;
                    end else begin
                        next_st.mode = pwdata[7:0];
                        next_st.mode_written = 1'b1;
                        set_bits[ST_MODE] = 1'b1;
                        if (!st.opt_stoppable) begin
                            next_st.mode[MODE_FIX_HI:MODE_FIX_LO] = MODE_FIXED;
                        end else if (pwdata[MODE_STOP_BIT]) begin
                            next_st.stopped = 1'b1;
                        end
                    end
                end
                SEL_CLEAR: begin
                    if (pwdata[7:0] == CLEAR_CODE) begin
                        next_st.clear_req = 1'b1;
                    end else begin
                        next_st.viol = 1'b1;
                    end
                end
                SEL_CLEAR_BIT: next_st.viol = 1'b1;
                SEL_MODE_BIT:  next_st.viol = 1'b0;
                SEL_MASK:      next_st.mask = pwdata[ST_W-1:0];
                default:       next_st.viol = 1'b0;
            endcase
        end

        // Sticky events; a set in the clearing cycle wins
        set_bits[ST_VIOL] = next_st.viol;
        set_bits[ST_OVF] = overflow;
        set_bits[ST_RST] = rst_fire;
        if (wr_fire && sel == SEL_STATUS) begin
            next_st.status = st.status & ~pwdata[ST_W-1:0];
        end
        next_st.status = next_st.status | set_bits;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '{bus: BUS_IDLE, mode: MODE_RESET, status: ST_RESET,
                    mask: ST_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Counter and reset deferral
    // ----------------------------------------
    wdt_counter #(
        .CNT_W (CNT_W)
    ) u_cnt (
        .mclk     (mclk),
        .srst     (srst),
        .tick     (tick),
        .clear    (st.clear_req),
        .sel      (st.mode[MODE_SEL_HI:0]),
        .count    (count),
        .overflow (overflow)
    );

    // Overflow and access faults share one deferred reset path
    wdt_rst_defer u_defer (
        .mclk    (mclk),
        .srst    (srst),
        .cause   (st.viol || overflow),
        .src_run (src_run),
        .pending (pending),
        .fire    (rst_fire)
    );

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
    assign wdt_rst = rst_fire;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence mode_setup;
        st.bus == BUS_IDLE && setup && pwrite && sel == SEL_MODE;
    endsequence

    sequence one_wait;
        !pready ##1 pready;
    endsequence

    AST_MODE_WAIT: assert property (mode_setup |=> one_wait)
        else $error("mode write not stretched by one wait");

    AST_FIXED_BITS: assert property (
        st.mode_written && !st.opt_stoppable |-> st.mode[MODE_FIX_HI:MODE_FIX_LO] == MODE_FIXED)
        else $error("mode top bits not 011");

    AST_SECOND_WRITE: assert property (
        wr_fire && sel == SEL_MODE && st.mode_written |=> st.viol ##1 pending || rst_fire)
        else $error("second mode write did not raise reset");

    AST_STOP_HOLD: assert property (
        st.stopped && !st.clear_req |=> count == $past(count))
        else $error("stopped watchdog still counting");

    AST_BAD_CLEAR: assert property (
        wr_fire && sel == SEL_CLEAR && pwdata[7:0] != CLEAR_CODE |=> st.viol)
        else $error("bad clear code did not raise reset");

    AST_BIT_CLEAR: assert property (wr_fire && sel == SEL_CLEAR_BIT |=> st.viol)
        else $error("bit access to clear register ignored");

    AST_READ_CODE: assert property (
        fire && !pwrite && sel == SEL_CLEAR |-> prdata[7:0] == CLEAR_READ)
        else $error("clear register read wrong value");

    // A tick in stop must still move the count when the oscillator cannot stop
    AST_NONSTOP: assert property (
        st.opt_taken && !st.opt_stoppable && halt_stop && !st.clear_req
        && (st.mode[MODE_SRC_BIT] ? tick_sys : tick_osc) |=> count != $past(count))
        else $error("non-stoppable watchdog paused");

    AST_HALT_HOLD: assert property (
        st.opt_stoppable && halt_stop && !st.clear_req |=> count == $past(count))
        else $error("count moved during halt");

    AST_CLEAR_GOOD: assert property (
        wr_fire && sel == SEL_CLEAR && pwdata[7:0] == CLEAR_CODE |=> st.clear_req ##1 count == '0)
        else $error("clear code did not zero counter");
endmodule : wdt_guard
`default_nettype wire

// ### test/test_watchdog_guarded_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_guarded_access;
    import wdt_pkg::*;

    // Bench signals
    logic                mclk, srst, psel, penable, pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, last_rd;
    logic                pready, pslverr, last_err;
    logic                tick_osc, tick_sys, osc_stoppable, halt_stop, wdt_rst, irq;
    logic [7:0]          lfsr;
    logic                sys_on;
    int                  mismatches, total_checks, last_lat, rst_seen;
    logic [31:0]         a, b;

    wdt_guard DUT (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tick_osc(tick_osc), .tick_sys(tick_sys),
        .osc_stoppable(osc_stoppable), .halt_stop(halt_stop), .wdt_rst(wdt_rst), .irq(irq));

    // ----------------------------------------
    // Clock, ticks and reset monitor
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // Stored mode: top bits forced to 011 unless the oscillator may stop
    function automatic logic [31:0] mode_exp(input logic [7:0] w, input logic stoppable);
        return {24'h0, stoppable ? w : {MODE_FIXED, w[4:0]}};
    endfunction : mode_exp

    // Random oscillator ticks so counts move unevenly
    always @(posedge mclk) begin
        lfsr     <= lfsr_next(lfsr);
        tick_osc <= lfsr[0];
        tick_sys <= sys_on;
        if (wdt_rst === 1'b1) rst_seen <= rst_seen + 1;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // APB master and helpers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge mclk);
        penable  <= 1'b1;
        last_lat = 0;
        // Bounded wait: a slave that never answers ends the run
        do begin
            @(posedge mclk);
            last_lat++;
        end while (pready !== 1'b1 && last_lat < 20);
        if (last_lat >= 20) begin
            mismatches++;
            complete_run();
        end
        last_rd  = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset(input logic strap);
        srst          <= 1'b1;
        osc_stoppable <= strap;
        halt_stop     <= 1'b0;
        sys_on        <= 1'b0;
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
    endtask : do_reset

    // Counts internal reset pulses over a fixed span
    task automatic rst_exp(input int n, input int e);
        int c;
        c = rst_seen;
        repeat (n) @(posedge mclk);
        chk("wdt_rst", 32'(rst_seen - c), 32'(e));
    endtask : rst_exp

    initial begin
        #(25ns * 60000);
        mismatches++;
        complete_run();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = '0;
        {tick_osc, tick_sys, osc_stoppable, halt_stop, sys_on} = '0;
        lfsr = 8'h3b;
        mismatches = 0;
        total_checks = 0;
        rst_seen = 0;
        do_reset(1'b0);
        // Reset values, read code, unmapped access
        apb(1'b0, OFF_MODE, '0);
        chk("mode_reset", last_rd, 32'h67);
        apb(1'b0, OFF_CLEAR, '0);
        chk("clear_read", last_rd, {24'h0, CLEAR_READ});
        apb(1'b0, 8'h1c, '0);
        chk("unmapped_err", 32'(last_err), 32'h1);
        // Interrupt on mode accepted, mask and W1C
        apb(1'b1, OFF_MASK, 32'h1);
        apb(1'b1, OFF_MODE, 32'h1f);
        chk("mode_wait", 32'(last_lat), 32'h2);
        rst_exp(3, 0);
        chk("irq_set", 32'(irq), 32'h1);
        apb(1'b0, OFF_MODE, '0);
        chk("mode_fixed", last_rd, mode_exp(8'h1f, 1'b0));
        chk("read_lat", 32'(last_lat), 32'h1);
        apb(1'b1, OFF_MASK, 32'h0);
        rst_exp(2, 0);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, OFF_MASK, 32'h1);
        rst_exp(2, 0);
        chk("irq_unmask", 32'(irq), 32'h1);
        apb(1'b1, OFF_STATUS, 32'h1);
        rst_exp(2, 0);
        chk("irq_clear", 32'(irq), 32'h0);
        // Non-stoppable keeps counting in stop; mode picked the alternate source
        halt_stop <= 1'b1;
        sys_on    <= 1'b1;
        apb(1'b0, OFF_STATE, '0);
        a = last_rd;
        repeat (20) @(posedge mclk);
        apb(1'b0, OFF_STATE, '0);
        chk("run_in_stop", 32'(last_rd[17:0] > a[17:0]), 32'h1);
        halt_stop <= 1'b0;
        // Second mode write raises reset
        apb(1'b1, OFF_MODE, 32'h67);
        rst_exp(4, 1);
        // Bad clear codes, random among them
        for (int i = 0; i < 6; i++) begin
            do_reset(1'b0);
            b = {24'h0, (lfsr == CLEAR_CODE) ? 8'h00 : lfsr};
            apb(1'b1, OFF_CLEAR, (i == 0) ? 32'h0 : (i == 1) ? 32'hff : b);
            chk("clear_lat", 32'(last_lat), 32'h1);
            rst_exp(4, 1);
        end
        // Bit access: clear alias resets, mode alias ignored
        do_reset(1'b0);
        apb(1'b1, OFF_MODE_BIT, 32'h10);
        rst_exp(4, 0);
        apb(1'b1, OFF_CLEAR_BIT, 32'hac);
        rst_exp(4, 1);
        // Clear code restarts the interval: fast source, shortest interval
        do_reset(1'b0);
        apb(1'b1, OFF_MODE, 32'h68);
        sys_on <= 1'b1;
        apb(1'b1, OFF_CLEAR, {24'h0, CLEAR_CODE});
        rst_exp(900, 0);
        apb(1'b1, OFF_CLEAR, {24'h0, CLEAR_CODE});
        apb(1'b0, OFF_STATE, '0);
        chk("count_cleared", 32'(last_rd[17:0] < 18'h8), 32'h1);
        rst_exp(900, 0);
        rst_exp(300, 1);
        // Halt pauses, violation deferred until source runs
        do_reset(1'b1);
        halt_stop <= 1'b1;
        apb(1'b0, OFF_STATE, '0);
        a = last_rd;
        apb(1'b1, OFF_CLEAR, 32'h55);
        rst_exp(10, 0);
        apb(1'b0, OFF_STATE, '0);
        chk("held_count", {14'h0, last_rd[17:0]}, {14'h0, a[17:0]});
        halt_stop <= 1'b0;
        rst_exp(4, 1);
        apb(1'b0, OFF_STATE, '0);
        chk("resumed", 32'(last_rd[17:0] >= a[17:0]), 32'h1);
        // Stop bit halts for good; later violation stays pending
        do_reset(1'b1);
        apb(1'b1, OFF_MODE, 32'h70);
        apb(1'b0, OFF_STATE, '0);
        a = last_rd;
        apb(1'b1, OFF_MODE, 32'h60);
        rst_exp(30, 0);
        apb(1'b0, OFF_STATE, '0);
        chk("stopped_count", {14'h0, last_rd[17:0]}, {14'h0, a[17:0]});
        chk("pending", 32'(last_rd[29]), 32'h1);
        complete_run();
    end

endmodule : test_watchdog_guarded_access
`default_nettype wire
